// >>> core/result_fifo.sv
// result buffer: parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
module result_fifo
  import sar_readout_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
    logic empty;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  assign do_push = in_valid_i & ~st.full & ce_i;
  assign do_pop = out_ready_i & ~st.empty & ce_i;
  assign in_ready_o = ~st.full;
  assign out_valid_o = ~st.empty;
  assign out_data_o = mem[st.rd_ptr];

  // pointers and flags; depth is a power of two so pointers wrap by themselves
  always_comb begin
    next_st = st;
    if (do_push) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    case ({do_push, do_pop})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
    next_st.full = (next_st.count == (AW+1)'(DEPTH));
    next_st.empty = (next_st.count == '0);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // storage has no reset: nothing is read before it is written
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[st.wr_ptr] <= in_data_i;
    end
  end

endmodule

// >>> core/sar_adc_serial_readout.sv
// serial conversion and readout sequencer of a twelve bit successive approximation converter
`timescale 1ns/1ps
module sar_adc_serial_readout
  import sar_readout_pkg::*;
#(
  parameter int BUF_WIDTH = FIFO_WIDTH,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic select_shutdown_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic comparator_high_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output logic track_o,
  output logic analog_power_o,
  output logic digital_power_o,
  output logic [RES_BITS-1:0] trial_code_o,
  output logic [BUF_WIDTH-1:0] result_data_o,
  output logic result_valid_o,
  input wire logic result_ready_i
);

  // one frame, counted in falling bit clock edges after select goes low:
  //   fall 1: still tracking the input
  //   fall 2: input held, line enabled with the low null bit
  //   falls 3 to 14: decided bits, top bit first, with no pipeline delay
  //   falls 15 to 26: the same result again, bottom bit first
  //   fall 27: line released; later falls are ignored until select toggles
  // every pin edge reaches the outputs three system clocks late (two
  // synchroniser stages and the state register), so each bit clock level
  // must last at least one system clock or an edge is lost

  // whole state of the sequencer in one record
  typedef struct packed {
    // pin synchronisers, with one-clock-old copies of the select and clock stages
    logic sel_s1;
    logic sel_s2;
    logic sel_prev;
    logic clk_s1;
    logic clk_s2;
    logic clk_prev;
    logic cmp_s1;
    logic cmp_s2;
    // clocks since reset, saturating once the synchronisers hold real pins
    logic [1:0] settle;
    // sequencing
    phase_t phase;
    logic [1:0] fall_cnt;
    logic [3:0] bit_idx;
    logic [RES_BITS-1:0] result;
    logic [RES_BITS-1:0] trial;
    // registered pin outputs and power controls
    logic dout;
    logic oe;
    logic track;
    logic analog_on;
    logic digital_on;
    // finished result waiting for room in the buffer
    logic push_pend;
    logic [RES_BITS-1:0] push_data;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  // derived events from the synchronised pins
  logic sel_fall;
  logic sel_high;
  logic clk_fall;
  logic decided;
  logic [RES_BITS-1:0] decided_result;
  logic fifo_in_ready;
  logic pins_settled;

  // one-hot weight of a result bit
  function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = RES_BITS'(1) << idx;
  endfunction

  // result with one bit forced to a value
  function automatic logic [RES_BITS-1:0] put_bit(
    input logic [RES_BITS-1:0] code,
    input logic [3:0] idx,
    input logic val
  );
    put_bit = val ? (code | bit_mask(idx)) : (code & ~bit_mask(idx));
  endfunction

  // next lower result bit position; only used above the bottom bit
  function automatic logic [3:0] idx_down(input logic [3:0] idx);
    idx_down = idx - 4'h1;
  endfunction

  // edge detection only ever looks at the second synchroniser stage
  // the old copy of the select and clock stages turns each falling pin edge into a one-clock strobe
  assign sel_high = st.sel_s2;
  assign sel_fall = st.sel_prev & ~st.sel_s2;
  assign clk_fall = st.clk_prev & ~st.clk_s2;

  // comparator high means the held input is at or above the trial code
  // the verdict is two clocks old, long settled after a whole bit period
  assign decided = st.cmp_s2;
  assign decided_result = put_bit(st.result, st.bit_idx, decided);

  // the synchronisers leave reset at the idle levels, so a select already low
  // at release would look like a fall; starts wait until the stages hold pins
  assign pins_settled = &st.settle;

  // next state of the whole sequencer
  always_comb begin
    // every field holds unless a branch below says otherwise
    next_st = st;

    // two flip-flops on every pin before any logic uses it
    next_st.sel_s1 = select_shutdown_n_i;
    next_st.sel_s2 = st.sel_s1;
    next_st.sel_prev = st.sel_s2;
    next_st.clk_s1 = serial_bit_clock_i;
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_prev = st.clk_s2;
    next_st.cmp_s1 = comparator_high_i;
    next_st.cmp_s2 = st.cmp_s1;

    // count the first clocks after reset, then stop
    if (!pins_settled) begin
      next_st.settle = st.settle + 2'h1;
    end

    // a held result leaves once the buffer takes it; a conversion end in the
    // same clock sets it again below, and that set wins
    if (st.push_pend && fifo_in_ready) begin
      next_st.push_pend = 1'b0;
    end

    if (sel_high) begin
      // select high is shutdown: abort wherever we are and release the line
      // bits of a frame cut short stay valid for the host; nothing is kept here
      next_st.phase = ST_SHUTDOWN;
      next_st.oe = 1'b0;
      next_st.dout = 1'b0;
      next_st.track = 1'b0;
      next_st.analog_on = 1'b0;
      next_st.digital_on = 1'b0;
      next_st.fall_cnt = 2'h0;
    end else begin
      // digital section stays alive for as long as select is low
      next_st.digital_on = 1'b1;

      case (st.phase)
        ST_SHUTDOWN: begin
          // only a fresh high-to-low select starts a cycle; a low select that
          // never went high, or a result still waiting for the buffer, does not
          if (sel_fall && !st.push_pend && pins_settled) begin
            next_st.phase = ST_TRACK;
            next_st.track = 1'b1;
            next_st.analog_on = 1'b1;
            next_st.fall_cnt = 2'h0;
            next_st.result = CODE_ZERO;
            next_st.trial = CODE_MID;
            next_st.bit_idx = TOP_BIT_IDX;
          end
        end

        ST_TRACK: begin
          // input is tracked until the second falling bit clock edge, which
          // gives 1.5 to 2 periods depending on clock phase at select fall
          if (clk_fall) begin
            next_st.fall_cnt = st.fall_cnt + 2'h1;
            if ((st.fall_cnt + 2'h1) == NULL_FALL_EDGE) begin
              next_st.track = 1'b0;
              next_st.phase = ST_NULL;
              next_st.oe = 1'b1;
              next_st.dout = 1'b0;
              next_st.bit_idx = TOP_BIT_IDX;
            end
          end
        end

        ST_NULL, ST_MSB_OUT: begin
          // one bit decision per period; the decided bit goes straight out so
          // there is no pipeline delay between conversion and transfer
          if (clk_fall) begin
            next_st.dout = decided;
            next_st.result = decided_result;
            if (st.bit_idx == BOTTOM_BIT_IDX) begin
              // conversion complete: analog off, result queued for the buffer
              next_st.analog_on = 1'b0;
              next_st.trial = decided_result;
              next_st.push_pend = 1'b1;
              next_st.push_data = decided_result;
              next_st.phase = ST_LSB_OUT;
              next_st.bit_idx = BOTTOM_BIT_IDX;
            end else begin
              // next trial weight halves the step; one step is full scale/4096
              next_st.phase = ST_MSB_OUT;
              next_st.bit_idx = idx_down(st.bit_idx);
              next_st.trial = decided_result | bit_mask(idx_down(st.bit_idx));
            end
          end
        end

        ST_LSB_OUT: begin
          // repeat of the result, bottom bit first
          // the bottom bit goes out a second time as the first of this pass
          if (clk_fall) begin
            next_st.dout = st.result[st.bit_idx];
            if (st.bit_idx == TOP_BIT_IDX) begin
              next_st.phase = ST_TAIL;
            end else begin
              next_st.bit_idx = st.bit_idx + 4'h1;
            end
          end
        end

        ST_TAIL: begin
          // top bit has stood for its period; release the line on the next fall
          // the line level is forced low so a released output shows no stale bit
          if (clk_fall) begin
            next_st.oe = 1'b0;
            next_st.dout = 1'b0;
            next_st.phase = ST_QUIET;
          end
        end

        ST_QUIET: begin
          // further clocks do nothing until select is toggled
          // the digital section stays powered here until select rises
          next_st.oe = 1'b0;
        end

        default: begin
          // an illegal phase code falls back to shutdown with the line released
          next_st.phase = ST_SHUTDOWN;
          next_st.oe = 1'b0;
          next_st.track = 1'b0;
          next_st.analog_on = 1'b0;
        end
      endcase
    end
  end

  // the clock enable freezes every bit of state, synchronisers included
  // limitation: pin edges that come and go while it is low are missed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{
        sel_s1: 1'b1,
        sel_s2: 1'b1,
        sel_prev: 1'b1,
        clk_s1: 1'b0,
        clk_s2: 1'b0,
        clk_prev: 1'b0,
        cmp_s1: 1'b0,
        cmp_s2: 1'b0,
        settle: 2'h0,
        phase: ST_SHUTDOWN,
        fall_cnt: 2'h0,
        bit_idx: TOP_BIT_IDX,
        result: CODE_ZERO,
        trial: CODE_MID,
        dout: 1'b0,
        oe: 1'b0,
        track: 1'b0,
        analog_on: 1'b0,
        digital_on: 1'b0,
        push_pend: 1'b0,
        push_data: CODE_ZERO
      };
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // every pin-facing output is a register of the state record
  // nothing here is decoded, so no output glitches on a phase change
  assign serial_data_o = st.dout;
  assign serial_data_oe_o = st.oe;
  assign track_o = st.track;
  assign analog_power_o = st.analog_on;
  assign digital_power_o = st.digital_on;
  assign trial_code_o = st.trial;

  // finished results queue here for local readers; while the queue is full a
  // result waits in push_data and blocks the next start, so none is overwritten
  // the buffer shares the clock enable, so a frozen block neither pushes nor pops
  result_fifo #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_result_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_valid_i(st.push_pend),
    .in_ready_o(fifo_in_ready),
    .in_data_i(BUF_WIDTH'(st.push_data)),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o(result_data_o)
  );

endmodule

// >>> core/sar_readout_pkg.sv
// constants, phase encoding and shared types for the serial converter readout
// Behaviour
// - a falling select starts a new sample, conversion and serial transfer; a fall while a finished result still waits for the buffer starts nothing
// - track the input about two bit clock periods after select falls, then hold
// - on the second falling bit clock edge enable output and send one low null bit
// - then shift twelve result bits out, top bit first, one per period
// - further clocks with select low resend the result starting from the bottom bit
// - after the top bit is resent, release the output and ignore later clocks
// - a new conversion needs select raised and lowered again; host toggles select
// - the output bit changes on each falling bit clock edge
// - analog section powers down when conversion completes and while select is high
// - digital section shuts down only while select is high
// - the result is an unsigned straight binary twelve bit code
// - one code step equals the reference divided by 4096
// - zero gives 000, half gives 800, half less a step 7FF, top FFF
// - select low operates the device, select high shuts it down
// - raising select aborts at any bit; bits already sent stay valid
package sar_readout_pkg;

  // result format
  localparam int RES_BITS = 12;
  localparam int CODE_STEPS = 4096;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_MID_LESS = 12'h7FF;
  localparam logic [11:0] CODE_FULL = 12'hFFF;

  // bit positions in the result
  localparam logic [3:0] TOP_BIT_IDX = 4'hB;
  localparam logic [3:0] BOTTOM_BIT_IDX = 4'h0;

  // falling bit clock edge, counted from select falling, that ends tracking
  localparam logic [1:0] NULL_FALL_EDGE = 2'h2;

  // result buffer shape
  localparam int FIFO_WIDTH = 12;
  localparam int FIFO_DEPTH = 32;

  // one-hot phases of a readout cycle
  typedef enum logic [6:0] {
    ST_SHUTDOWN = 7'h01,
    ST_TRACK = 7'h02,
    ST_NULL = 7'h04,
    ST_MSB_OUT = 7'h08,
    ST_LSB_OUT = 7'h10,
    ST_TAIL = 7'h20,
    ST_QUIET = 7'h40
  } phase_t;

endpackage

// >>> verification/host_master.sv
// host side model: select and bit clock master for the readout pins
`timescale 1ns/1ps
module host_master (
  input wire logic clk_i,
  output logic select_shutdown_n_o,
  output logic serial_bit_clock_o
);
  initial begin
    select_shutdown_n_o = 1'b1;
    serial_bit_clock_o = 1'b0;
  end

  // four clocks a phase keeps each level well above the sync minimum
  task automatic half();
    repeat (4) @(posedge clk_i);
    #2;
  endtask

  // select low, npulse bit clocks, then select high; the clock idles low outside frames
  task automatic frame(input int npulse);
    select_shutdown_n_o = 1'b0;
    for (int i = 0; i < npulse; i++) begin
      half();
      serial_bit_clock_o = 1'b1;
      half();
      serial_bit_clock_o = 1'b0;
    end
    half();
    select_shutdown_n_o = 1'b1;
    repeat (4) half();
  endtask
endmodule

// >>> verification/sar_readout_monitor.sv
// checker for the readout pins and the result stream of the converter sequencer
`timescale 1ns/1ps
module sar_readout_monitor #(
  parameter int BUF_WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic select_shutdown_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic track_o,
  input wire logic analog_power_o,
  input wire logic digital_power_o,
  input wire logic [BUF_WIDTH-1:0] result_data_o,
  input wire logic result_valid_o,
  input wire logic result_ready_i
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // pin edges reach the outputs three clocks late, through the synchroniser
  sequence bit_clock_fell;
    $past(serial_bit_clock_i, 4) && !$past(serial_bit_clock_i, 3);
  endsequence
  sequence select_fell;
    $past(select_shutdown_n_i, 4) && !$past(select_shutdown_n_i, 3);
  endsequence

  AST_TRACK_START: assert property ($rose(track_o) |-> select_fell)
    else $error("tracking began without a select fall");
  property null_after_track;
    $fell(track_o) && digital_power_o |-> serial_data_oe_o && !serial_data_o;
  endproperty
  property bit_moves_on_fall;
    serial_data_oe_o && $changed(serial_data_o) |-> bit_clock_fell;
  endproperty
  property release_moment;
    $fell(serial_data_oe_o) |-> !digital_power_o or bit_clock_fell;
  endproperty
  property off_after_select_rise;
    $rose(select_shutdown_n_i) |-> ##3 !serial_data_oe_o && !analog_power_o;
  endproperty
  property stalled_word_holds;
    result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_data_o);
  endproperty

  AST_NULL_BIT: assert property (null_after_track)
    else $error("hold did not start with a low null bit");
  AST_OE_ON_FALL: assert property ($rose(serial_data_oe_o) |-> bit_clock_fell)
    else $error("output enabled off a falling bit clock");
  AST_BIT_ON_FALL: assert property (bit_moves_on_fall)
    else $error("data bit changed off a falling bit clock");
  AST_OE_OFF: assert property (release_moment)
    else $error("output released at a wrong moment");
  AST_RELEASE: assert property (off_after_select_rise)
    else $error("output or analog section still on after select rose");
  AST_DIG_OFF: assert property (select_shutdown_n_i [*4] |-> !digital_power_o)
    else $error("digital section on while select high");
  AST_DIG_ON: assert property (!select_shutdown_n_i [*4] |-> digital_power_o)
    else $error("digital section off while select low");
  AST_ANALOG_GATED: assert property (analog_power_o |-> digital_power_o)
    else $error("analog section on during shutdown");
  // a stalled word must stand until taken
  AST_FIFO_HOLD: assert property (stalled_word_holds)
    else $error("buffered result changed while stalled");
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the converter readout sequencer
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmp_hi = 1'b0;
  logic rdy = 1'b0;
  logic fill = 1'b0;
  logic [11:0] ain = 12'h000;
  wire sel_n;
  wire sclk;
  logic sdo, soe, trk, apw, dpw, rval;
  logic [11:0] trial, rdata;
  logic [1:0] exp_bits[$];
  logic [11:0] exp_res[$];
  int err_total = 0;
  int n_checks = 0;

  initial forever #12.5 clk = ~clk;

  sar_adc_serial_readout u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .select_shutdown_n_i(sel_n),
    .serial_bit_clock_i(sclk), .comparator_high_i(cmp_hi), .serial_data_o(sdo),
    .serial_data_oe_o(soe), .track_o(trk), .analog_power_o(apw), .digital_power_o(dpw),
    .trial_code_o(trial), .result_data_o(rdata), .result_valid_o(rval),
    .result_ready_i(rdy)
  );
  host_master u_host (.clk_i(clk), .select_shutdown_n_o(sel_n), .serial_bit_clock_o(sclk));

  // comparator model: held input against the trial code, read once it has settled
  always @(posedge clk) #2 cmp_hi <= (ain >= trial);
  // ready stalls at random, held low while the buffer is filled
  always @(posedge clk) rdy <= #2 fill ? 1'b0 : 1'($urandom_range(1, 0));

  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bits(input logic [1:0] got, input logic [1:0] exp);
    cmp_word({10'h000, got}, {10'h000, exp});
  endtask

  // {enable, bit} seen at rising bit clock k: null, top first, bottom first, then released
  function automatic logic [1:0] bit_at(input logic [11:0] c, input int k);
    if (k == 3) return 2'b10;
    if (k >= 4 && k <= 15) return {1'b1, c[15-k]};
    if (k >= 16 && k <= 27) return {1'b1, c[k-16]};
    return 2'b00;
  endfunction

  // ok low means the start is expected to be refused: line stays released
  task automatic conv(input logic [11:0] code, input int n, input logic ok);
    ain = code;
    for (int k = 1; k <= n; k++) exp_bits.push_back(ok ? bit_at(code, k) : 2'b00);
    if (ok && n >= 14) exp_res.push_back(code);
    u_host.frame(n);
  endtask

  task automatic drain();
    for (int i = 0; i < 2000 && exp_res.size() != 0; i++) @(posedge clk);
  endtask

  // the host samples on the rising bit clock edge
  always @(posedge sclk) begin
    if (exp_bits.size() != 0) begin
      cmp_bits({soe, soe & sdo}, exp_bits.pop_front());
    end
  end
  // results are looked at mid-cycle, clear of the edge that moves them
  always @(negedge clk) begin
    if (rval === 1'b1 && rdy === 1'b1 && exp_res.size() != 0) begin
      cmp_word(rdata, exp_res.pop_front());
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    static logic [11:0] corner[4] = '{sar_readout_pkg::CODE_ZERO, sar_readout_pkg::CODE_MID,
      sar_readout_pkg::CODE_MID_LESS, sar_readout_pkg::CODE_FULL};
    void'($urandom(68));
    repeat (5) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    foreach (corner[i]) conv(corner[i], 30, 1'b1);
    repeat (4) conv(12'($urandom), 28, 1'b1);
    conv(12'($urandom), 1, 1'b1);
    conv(12'($urandom), 8, 1'b1);
    conv(12'hA5C, 28, 1'b1);
    drain();
    fill = 1'b1;
    repeat (33) conv(12'($urandom), 14, 1'b1);
    conv(12'h3C3, 16, 1'b0);
    fill = 1'b0;
    drain();
    cmp_word(12'(exp_res.size() + exp_bits.size()), 12'h000);
    conclude();
  end

  // hang guard, well past the expected run of about seven thousand clocks
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule

bind sar_adc_serial_readout sar_readout_monitor #(.BUF_WIDTH(BUF_WIDTH)) u_mon (
  .clk_i, .rst_b_i, .select_shutdown_n_i, .serial_bit_clock_i, .serial_data_o,
  .serial_data_oe_o, .track_o, .analog_power_o, .digital_power_o, .result_data_o,
  .result_valid_o, .result_ready_i
);
